//--- pmon_pkg.sv
// package for the pump protection monitor: map, fields, resets, timing
package pmon_pkg;

    // ------------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] PMON_CTRL_ADDR   = 8'h00;
    localparam logic [7:0] PMON_IMAX_ADDR   = 8'h04;
    localparam logic [7:0] PMON_IMIN_ADDR   = 8'h08;
    localparam logic [7:0] PMON_COSMIN_ADDR = 8'h0c;
    localparam logic [7:0] PMON_DELAY_ADDR  = 8'h10;
    localparam logic [7:0] PMON_CONT_ADDR   = 8'h14;
    localparam logic [7:0] PMON_LIMIT_ADDR  = 8'h18;
    localparam logic [7:0] PMON_STATUS_ADDR = 8'h1c;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int PMON_CTRL_CONT_BIT  = 0;
    localparam int PMON_CTRL_MIN_BIT   = 1;
    localparam int PMON_CTRL_HOUR_BIT  = 2;
    localparam int PMON_CTRL_THERM_BIT = 3;
    localparam int PMON_CTRL_CLR_BIT   = 4;
    localparam int PMON_DLY_OC_LSB     = 0;
    localparam int PMON_DLY_UC_LSB     = 8;
    localparam int PMON_DLY_COS_LSB    = 16;
    localparam int PMON_LIM_MIN_LSB    = 0;
    localparam int PMON_LIM_HOUR_LSB   = 8;
    localparam int PMON_LIM_THERM_LSB  = 16;
    localparam int PMON_ST_RUN_BIT     = 8;
    localparam int PMON_ST_TCNT_LSB    = 16;

    // ------------------------------------------------------------------
    // reset values and legal ranges
    // ------------------------------------------------------------------
    localparam logic        PMON_CONT_EN_RST  = 1'b0;
    localparam logic        PMON_MIN_EN_RST   = 1'b1;
    localparam logic        PMON_HOUR_EN_RST  = 1'b0;
    localparam logic        PMON_THERM_EN_RST = 1'b1;
    localparam logic [9:0]  PMON_IMAX_RST     = 10'h000;
    localparam logic [9:0]  PMON_IMIN_RST     = 10'h000;
    localparam logic [6:0]  PMON_COSMIN_RST   = 7'h14;
    localparam logic [3:0]  PMON_OC_DLY_RST   = 4'h5;
    localparam logic [3:0]  PMON_OC_DLY_MIN   = 4'h5;
    localparam logic [3:0]  PMON_OC_DLY_MAX   = 4'hf;
    localparam logic [6:0]  PMON_DLY_RST      = 7'h03;
    localparam logic [6:0]  PMON_DLY_MIN      = 7'h01;
    localparam logic [6:0]  PMON_DLY_MAX      = 7'h78;
    localparam logic [13:0] PMON_CONT_RST     = 14'h05a0;
    localparam logic [13:0] PMON_CONT_MIN     = 14'h0001;
    localparam logic [13:0] PMON_CONT_MAX     = 14'h270f;
    localparam logic [3:0]  PMON_SMIN_RST     = 4'h9;
    localparam logic [3:0]  PMON_SMIN_MIN     = 4'h1;
    localparam logic [3:0]  PMON_SMIN_MAX     = 4'h9;
    localparam logic [6:0]  PMON_SHOUR_RST    = 7'h06;
    localparam logic [6:0]  PMON_SHOUR_MIN    = 7'h01;
    localparam logic [6:0]  PMON_SHOUR_MAX    = 7'h63;
    localparam logic [3:0]  PMON_TMAX_RST     = 4'h1;
    localparam logic [3:0]  PMON_TMAX_MIN     = 4'h1;
    localparam logic [3:0]  PMON_TMAX_MAX     = 4'ha;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int          PMON_CLK_MHZ      = 250;
    localparam int          PMON_TICK_MS      = 1000;
    localparam int          PMON_TICK_CYCLES  = PMON_TICK_MS * 1000
                                                * PMON_CLK_MHZ;
    localparam logic [5:0]  PMON_SEC_PER_MIN  = 6'h3c;
    localparam logic [5:0]  PMON_MIN_PER_HOUR = 6'h3c;

    // ------------------------------------------------------------------
    // alarm vector positions
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PMON_AL_OC    = 3'b000,
        PMON_AL_UC    = 3'b001,
        PMON_AL_DRY   = 3'b010,
        PMON_AL_CONT  = 3'b011,
        PMON_AL_SMIN  = 3'b100,
        PMON_AL_SHOUR = 3'b101
    } pmon_alarm_t;
    localparam int PMON_AL_THERM = 6;
    localparam int PMON_NUM_AL   = 7;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [9:0] current;
        logic [6:0] cosphi;
        logic       run_cmd;
        logic       therm_closed;
        logic       button;
    } pmon_sense_t;

    typedef struct packed {
        logic                   cont_en;
        logic                   min_en;
        logic                   hour_en;
        logic                   therm_en;
        logic [9:0]             imax;
        logic [9:0]             imin;
        logic [6:0]             cosmin;
        logic [3:0]             oc_dly;
        logic [6:0]             uc_dly;
        logic [6:0]             cos_dly;
        logic [13:0]            cont_lim;
        logic [3:0]             smin_lim;
        logic [6:0]             shour_lim;
        logic [3:0]             tmax;
    } pmon_cfg_t;

    typedef struct packed {
        pmon_cfg_t              cfg;
        logic                   clr;
        logic                   wr_pend;
        logic [7:0]             wr_addr;
        logic [31:0]            hrdata;
        logic [27:0]            div;
        logic [5:0]             sec;
        logic [5:0]             min;
        logic [6:0]             oc_cnt;
        logic [6:0]             uc_cnt;
        logic [6:0]             cos_cnt;
        logic [5:0]             run_sec;
        logic [13:0]            run_min;
        logic [3:0]             smin_cnt;
        logic [6:0]             shour_cnt;
        logic [3:0]             tcnt;
        logic                   run_cmd_q;
        logic                   therm_q;
        logic [PMON_NUM_AL-1:0] alarm;
        logic                   pump_run;
    } pmon_state_t;

endpackage

//--- pmon_monitor.sv
// pump protection monitor with its ahb-lite register slave
//
// Chosen here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps

module pmon_monitor
    import pmon_pkg::*;
#(
    parameter int TICK_CYCLES = PMON_TICK_CYCLES
) (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic                        hresp,
    output logic [31:0]                 hrdata,
    input  wire logic [9:0]             motor_current,
    input  wire logic [6:0]             motor_cosphi,
    input  wire logic                   run_cmd,
    input  wire logic                   therm_closed,
    input  wire logic                   pump_button,
    output logic                        pump_run,
    output logic [PMON_NUM_AL-1:0]      alarm
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [13:0] clamp(input logic [13:0] v,
                                          input logic [13:0] lo,
                                          input logic [13:0] hi);
        logic [13:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

    function automatic logic [31:0] read_reg(input logic [7:0] a,
                                             input pmon_state_t s);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            PMON_CTRL_ADDR: begin
                d[PMON_CTRL_CONT_BIT]  = s.cfg.cont_en;
                d[PMON_CTRL_MIN_BIT]   = s.cfg.min_en;
                d[PMON_CTRL_HOUR_BIT]  = s.cfg.hour_en;
                d[PMON_CTRL_THERM_BIT] = s.cfg.therm_en;
            end
            PMON_IMAX_ADDR:   d[9:0] = s.cfg.imax;
            PMON_IMIN_ADDR:   d[9:0] = s.cfg.imin;
            PMON_COSMIN_ADDR: d[6:0] = s.cfg.cosmin;
            PMON_DELAY_ADDR: begin
                d[PMON_DLY_OC_LSB +: 4]  = s.cfg.oc_dly;
                d[PMON_DLY_UC_LSB +: 7]  = s.cfg.uc_dly;
                d[PMON_DLY_COS_LSB +: 7] = s.cfg.cos_dly;
            end
            PMON_CONT_ADDR:   d[13:0] = s.cfg.cont_lim;
            PMON_LIMIT_ADDR: begin
                d[PMON_LIM_MIN_LSB +: 4]   = s.cfg.smin_lim;
                d[PMON_LIM_HOUR_LSB +: 7]  = s.cfg.shour_lim;
                d[PMON_LIM_THERM_LSB +: 4] = s.cfg.tmax;
            end
            PMON_STATUS_ADDR: begin
                d[PMON_NUM_AL-1:0]         = s.alarm;
                d[PMON_ST_RUN_BIT]         = s.pump_run;
                d[PMON_ST_TCNT_LSB +: 4]   = s.tcnt;
            end
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    pmon_state_t q;
    pmon_state_t next_q;
    pmon_sense_t sense;

    logic tick;
    logic min_end;
    logic hour_end;
    logic running;
    logic start_evt;
    logic trip_evt;
    logic oc_cond;
    logic uc_cond;
    logic cos_cond;
    logic reset_req;
    logic addr_ok;

    assign sense = '{current: motor_current, cosphi: motor_cosphi,
                     run_cmd: run_cmd, therm_closed: therm_closed,
                     button: pump_button};

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = q.hrdata;
    assign pump_run  = q.pump_run;
    assign alarm     = q.alarm;

    always_comb begin
        next_q = q;

        // --------------------------------------------------------------
        // time base
        // --------------------------------------------------------------
        tick     = (q.div == 28'(TICK_CYCLES - 1));
        min_end  = tick && (q.sec == PMON_SEC_PER_MIN - 6'h01);
        hour_end = min_end && (q.min == PMON_MIN_PER_HOUR - 6'h01);
        next_q.div = tick ? 28'h000_0000 : q.div + 28'h000_0001;
        if (tick) begin
            next_q.sec = min_end ? 6'h00 : q.sec + 6'h01;
        end
        if (min_end) begin
            next_q.min = hour_end ? 6'h00 : q.min + 6'h01;
        end

        // --------------------------------------------------------------
        // register bus
        // --------------------------------------------------------------
        addr_ok   = hsel && htrans[1] && hready;
        next_q.clr = 1'b0;
        next_q.wr_pend = addr_ok && hwrite;
        next_q.wr_addr = {haddr[7:2], 2'b00};
        if (addr_ok && !hwrite) begin
            next_q.hrdata = read_reg({haddr[7:2], 2'b00}, q);
        end
        if (q.wr_pend) begin
            case (q.wr_addr)
                PMON_CTRL_ADDR: begin
                    next_q.cfg.cont_en  = hwdata[PMON_CTRL_CONT_BIT];
                    next_q.cfg.min_en   = hwdata[PMON_CTRL_MIN_BIT];
                    next_q.cfg.hour_en  = hwdata[PMON_CTRL_HOUR_BIT];
                    next_q.cfg.therm_en = hwdata[PMON_CTRL_THERM_BIT];
                    next_q.clr          = hwdata[PMON_CTRL_CLR_BIT];
                end
                PMON_IMAX_ADDR:   next_q.cfg.imax   = hwdata[9:0];
                PMON_IMIN_ADDR:   next_q.cfg.imin   = hwdata[9:0];
                PMON_COSMIN_ADDR: next_q.cfg.cosmin = hwdata[6:0];
                PMON_DELAY_ADDR: begin
                    next_q.cfg.oc_dly = 4'(clamp(
                        14'(hwdata[PMON_DLY_OC_LSB +: 4]),
                        14'(PMON_OC_DLY_MIN), 14'(PMON_OC_DLY_MAX)));
                    next_q.cfg.uc_dly = 7'(clamp(
                        14'(hwdata[PMON_DLY_UC_LSB +: 7]),
                        14'(PMON_DLY_MIN), 14'(PMON_DLY_MAX)));
                    next_q.cfg.cos_dly = 7'(clamp(
                        14'(hwdata[PMON_DLY_COS_LSB +: 7]),
                        14'(PMON_DLY_MIN), 14'(PMON_DLY_MAX)));
                end
                PMON_CONT_ADDR: begin
                    next_q.cfg.cont_lim = clamp(hwdata[13:0],
                        PMON_CONT_MIN, PMON_CONT_MAX);
                end
                PMON_LIMIT_ADDR: begin
                    next_q.cfg.smin_lim = 4'(clamp(
                        14'(hwdata[PMON_LIM_MIN_LSB +: 4]),
                        14'(PMON_SMIN_MIN), 14'(PMON_SMIN_MAX)));
                    next_q.cfg.shour_lim = 7'(clamp(
                        14'(hwdata[PMON_LIM_HOUR_LSB +: 7]),
                        14'(PMON_SHOUR_MIN), 14'(PMON_SHOUR_MAX)));
                    next_q.cfg.tmax = 4'(clamp(
                        14'(hwdata[PMON_LIM_THERM_LSB +: 4]),
                        14'(PMON_TMAX_MIN), 14'(PMON_TMAX_MAX)));
                end
                default: next_q.clr = 1'b0;
            endcase
        end

        // --------------------------------------------------------------
        // events
        // --------------------------------------------------------------
        running   = q.pump_run;
        reset_req = sense.button || q.clr;
        next_q.run_cmd_q = sense.run_cmd;
        next_q.therm_q   = sense.therm_closed;
        start_evt = sense.run_cmd && !q.run_cmd_q;
        trip_evt  = q.therm_q && !sense.therm_closed;

        // zero threshold setting disables the current checks
        oc_cond  = running && (q.cfg.imax != 10'h000)
                   && (sense.current > q.cfg.imax);
        uc_cond  = running && (q.cfg.imin != 10'h000)
                   && (sense.current < q.cfg.imin);
        cos_cond = running && (q.cfg.cosmin != 7'h00)
                   && (sense.cosphi < q.cfg.cosmin);

        // --------------------------------------------------------------
        // operator reset of latched alarms
        // --------------------------------------------------------------
        if (reset_req) begin
            next_q.alarm[PMON_AL_OC]    = 1'b0;
            next_q.alarm[PMON_AL_UC]    = 1'b0;
            next_q.alarm[PMON_AL_DRY]   = 1'b0;
            next_q.alarm[PMON_AL_CONT]  = 1'b0;
            next_q.alarm[PMON_AL_THERM] = 1'b0;
            next_q.tcnt                 = 4'h0;
        end

        // --------------------------------------------------------------
        // qualifying timers, restart on dropout
        // --------------------------------------------------------------
        // alarm on the tick after the delay is full, so the tick
        // phase can never shorten the qualifying time
        if (!oc_cond) begin
            next_q.oc_cnt = 7'h00;
        end else if (tick) begin
            next_q.oc_cnt = q.oc_cnt + 7'h01;
            if (q.oc_cnt >= 7'(q.cfg.oc_dly)) begin
                next_q.alarm[PMON_AL_OC] = 1'b1;
            end
        end
        if (!uc_cond) begin
            next_q.uc_cnt = 7'h00;
        end else if (tick) begin
            next_q.uc_cnt = q.uc_cnt + 7'h01;
            if (q.uc_cnt >= q.cfg.uc_dly) begin
                next_q.alarm[PMON_AL_UC] = 1'b1;
            end
        end
        if (!cos_cond) begin
            next_q.cos_cnt = 7'h00;
        end else if (tick) begin
            next_q.cos_cnt = q.cos_cnt + 7'h01;
            if (q.cos_cnt >= q.cfg.cos_dly) begin
                next_q.alarm[PMON_AL_DRY] = 1'b1;
            end
        end

        // --------------------------------------------------------------
        // continuous running
        // --------------------------------------------------------------
        if (!running) begin
            next_q.run_sec = 6'h00;
            next_q.run_min = 14'h0000;
        end else if (tick) begin
            if (q.run_sec == PMON_SEC_PER_MIN - 6'h01) begin
                next_q.run_sec = 6'h00;
                if (q.run_min != PMON_CONT_MAX) begin
                    next_q.run_min = q.run_min + 14'h0001;
                end
                // full minutes beyond the limit: the run is longer
                if (q.cfg.cont_en && q.run_min >= q.cfg.cont_lim) begin
                    next_q.alarm[PMON_AL_CONT] = 1'b1;
                end
            end else begin
                next_q.run_sec = q.run_sec + 6'h01;
            end
        end

        // --------------------------------------------------------------
        // start counting per minute and per hour
        // --------------------------------------------------------------
        if (min_end) begin
            next_q.smin_cnt = 4'h0;
            next_q.alarm[PMON_AL_SMIN] = 1'b0;
        end else if (start_evt) begin
            if (q.smin_cnt != 4'hf) begin
                next_q.smin_cnt = q.smin_cnt + 4'h1;
            end
            if (q.cfg.min_en && q.smin_cnt + 4'h1 > q.cfg.smin_lim) begin
                next_q.alarm[PMON_AL_SMIN] = 1'b1;
            end
        end
        if (hour_end) begin
            next_q.shour_cnt = 7'h00;
            next_q.alarm[PMON_AL_SHOUR] = 1'b0;
        end else if (start_evt) begin
            if (q.shour_cnt != 7'h7f) begin
                next_q.shour_cnt = q.shour_cnt + 7'h01;
            end
            if (q.cfg.hour_en
                && q.shour_cnt + 7'h01 > q.cfg.shour_lim) begin
                next_q.alarm[PMON_AL_SHOUR] = 1'b1;
            end
        end

        // --------------------------------------------------------------
        // thermal trips, no time window
        // --------------------------------------------------------------
        if (trip_evt) begin
            if (next_q.tcnt != 4'hf) begin
                next_q.tcnt = next_q.tcnt + 4'h1;
            end
        end
        if (q.cfg.therm_en && next_q.tcnt > q.cfg.tmax) begin
            next_q.alarm[PMON_AL_THERM] = 1'b1;
        end

        // --------------------------------------------------------------
        // pump drive: any alarm stops and inhibits the pump
        // --------------------------------------------------------------
        next_q.pump_run = sense.run_cmd && (next_q.alarm == '0);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q                <= '0;
            q.cfg.cont_en    <= PMON_CONT_EN_RST;
            q.cfg.min_en     <= PMON_MIN_EN_RST;
            q.cfg.hour_en    <= PMON_HOUR_EN_RST;
            q.cfg.therm_en   <= PMON_THERM_EN_RST;
            q.cfg.imax       <= PMON_IMAX_RST;
            q.cfg.imin       <= PMON_IMIN_RST;
            q.cfg.cosmin     <= PMON_COSMIN_RST;
            q.cfg.oc_dly     <= PMON_OC_DLY_RST;
            q.cfg.uc_dly     <= PMON_DLY_RST;
            q.cfg.cos_dly    <= PMON_DLY_RST;
            q.cfg.cont_lim   <= PMON_CONT_RST;
            q.cfg.smin_lim   <= PMON_SMIN_RST;
            q.cfg.shour_lim  <= PMON_SHOUR_RST;
            q.cfg.tmax       <= PMON_TMAX_RST;
            q.therm_q        <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

endmodule

//--- pmon_monitor_asserts.sv
// port checker for the pump protection monitor
`timescale 1ns/1ps
module pmon_monitor_asserts
    import pmon_pkg::*;
(
    input wire logic                   hclk,
    input wire logic                   hresetn,
    input wire logic                   hsel,
    input wire logic                   run_cmd,
    input wire logic                   therm_closed,
    input wire logic                   pump_button,
    input wire logic                   pump_run,
    input wire logic [PMON_NUM_AL-1:0] alarm
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_stop; pump_run |-> alarm == '0; endproperty
    a_stop: assert property (p_stop)
        else $error("pump runs while an alarm stands");
    property p_off; !run_cmd |=> !pump_run; endproperty
    a_off: assert property (p_off)
        else $error("pump runs without a run command");
    property p_oc; $rose(alarm[0]) |-> $past(pump_run); endproperty
    a_oc: assert property (p_oc)
        else $error("overcurrent alarm on a stopped pump");
    property p_start;
        $rose(alarm[4]) |-> $past(run_cmd) && !$past(run_cmd, 2);
    endproperty
    a_start: assert property (p_start)
        else $error("start alarm without a start");
    property p_trip; $rose(alarm[6]) |-> !$past(therm_closed); endproperty
    a_trip: assert property (p_trip)
        else $error("thermal alarm without contact opening");
    property p_clr;
        pump_button && !pump_run |=> alarm[3:0] == 4'h0;
    endproperty
    a_clr: assert property (p_clr)
        else $error("button did not clear latched alarms");
    property p_hold;
        alarm[6] && !pump_button && !hsel && !$past(hsel)
            && !$past(hsel, 2) |=> alarm[6];
    endproperty
    a_hold: assert property (p_hold)
        else $error("thermal alarm dropped without reset");
    property p_rise; $rose(pump_run) |-> $past(run_cmd); endproperty
    a_rise: assert property (p_rise)
        else $error("pump started without command");
endmodule
bind pmon_monitor pmon_monitor_asserts pmon_monitor_asserts_inst (.hclk,
    .hresetn, .hsel, .run_cmd, .therm_closed, .pump_button, .pump_run,
    .alarm);

//--- pmon_pump_model.sv
// pump motor sensing and thermal contact model
`timescale 1ns/1ps
module pmon_pump_model (
    input  wire logic       hclk,
    input  wire logic       pump_run,
    input  wire logic [9:0] load_amps,
    input  wire logic [6:0] load_cos,
    input  wire logic       trip,
    output logic [9:0]      motor_current,
    output logic [6:0]      motor_cosphi,
    output logic            therm_closed
);
    logic [2:0] hot = 3'h0;
    // a stopped motor draws nothing
    assign motor_current = pump_run ? load_amps : 10'h000;
    assign motor_cosphi  = pump_run ? load_cos : 7'h00;
    // contact opens on a trip and recloses itself once cool
    assign therm_closed  = (hot == 3'h0);
    always @(posedge hclk) begin
        if (trip)
            hot <= 3'h4;
        else if (hot != 3'h0)
            hot <= hot - 3'h1;
    end
endmodule

//--- tb_pump_protection_monitor.sv
// self-checking bench for the pump protection monitor
`timescale 1ns/1ps
module tb_pump_protection_monitor;
    import pmon_pkg::*;
    logic hclk, hresetn, hsel, hwrite, run_cmd, pump_button, trip;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [9:0] load_amps, motor_current;
    logic [6:0] load_cos, motor_cosphi;
    logic [PMON_NUM_AL-1:0] alarm;
    logic hreadyout, hresp, pump_run, therm_closed;
    wire hready = hreadyout;
    int n_mismatch = 0, cmp_count = 0;
    pmon_monitor #(.TICK_CYCLES(10)) pmon_monitor_inst (.hclk, .hresetn,
        .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hresp, .hrdata, .motor_current, .motor_cosphi,
        .run_cmd, .therm_closed, .pump_button, .pump_run, .alarm);
    pmon_pump_model pmon_pump_model_inst (.hclk, .pump_run, .load_amps,
        .load_cos, .trip, .motor_current, .motor_cosphi, .therm_closed);
    task automatic stop_test;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s exp %h got %h", s, e, g);
        end
    endtask
    function automatic logic [31:0] st;
        return {24'h0, alarm, pump_run};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic wt(input int b, input logic v);
        for (int i = 0; i < 40000; i++) begin
            @(posedge hclk);
            if (alarm[b] === v)
                return;
        end
        n_mismatch++;
        stop_test();
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        wt_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wt_rdy();
        q = hrdata;
        chk("hresp", 32'h0, 32'(hresp));
    endtask
    task automatic wt_rdy;
        for (int i = 0; i < 50; i++) begin
            @(posedge hclk);
            if (hready === 1'b1)
                return;
        end
        n_mismatch++;
        stop_test();
    endtask
    task automatic press;
        pump_button <= 1'b1;
        @(posedge hclk);
        pump_button <= 1'b0;
        cyc(3);
    endtask
    task automatic t_reset;
        logic [7:0] a[6] = '{8'h00, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h20};
        logic [31:0] e[6] = '{32'h0a, 32'h14, 32'h030305, 32'h05a0,
                              32'h010609, 32'h0};
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, a[i], 32'h0);
            chk("reset reg", e[i], q);
        end
    endtask
    task automatic t_oc;
        bus(1'b1, 8'h10, 32'h030302);
        bus(1'b0, 8'h10, 32'h0);
        chk("oc delay", 32'h030305, q);
        bus(1'b1, 8'h04, 32'h64);
        load_amps <= 10'h096;
        run_cmd <= 1'b1;
        cyc(30);
        load_amps <= 10'h032;
        cyc(20);
        load_amps <= 10'h096;
        cyc(45);
        chk("short excursion", 32'h01, st());
        cyc(20);
        chk("overcurrent", 32'h02, st());
        bus(1'b0, 8'h1c, 32'h0);
        chk("status", 32'h01, q);
        load_amps <= 10'h032;
        press();
        chk("after reset", 32'h01, st());
        run_cmd <= 1'b0;
        cyc(3);
    endtask
    task automatic start_pulse;
        run_cmd <= 1'b1;
        cyc(3);
        run_cmd <= 1'b0;
        cyc(3);
    endtask
    task automatic t_starts;
        bus(1'b1, 8'h18, 32'h020600);
        bus(1'b0, 8'h18, 32'h0);
        chk("limits", 32'h020601, q);
        start_pulse();
        start_pulse();
        chk("over limit", 32'h20, st());
        wt(4, 1'b0);
        start_pulse();
        chk("one start", 32'h0, st());
        start_pulse();
        chk("two starts", 32'h20, st());
        wt(4, 1'b0);
        chk("minute end", 32'h0, st());
    endtask
    task automatic t_therm;
        for (int i = 0; i < 3; i++) begin
            chk("trips", 32'h0, st());
            trip <= 1'b1;
            @(posedge hclk);
            trip <= 1'b0;
            cyc(60);
        end
        chk("trip alarm", 32'h80, st());
        bus(1'b0, 8'h1c, 32'h0);
        chk("trip count", 32'h030040, q);
        bus(1'b1, 8'h00, 32'h1a);
        cyc(2);
        chk("trip reset", 32'h0, st());
    endtask
    task automatic t_cont;
        bus(1'b1, 8'h14, 32'h0);
        bus(1'b1, 8'h00, 32'h0b);
        run_cmd <= 1'b1;
        cyc(1150);
        chk("running", 32'h01, st());
        wt(3, 1'b1);
        cyc(5);
        chk("long run", 32'h10, st());
        press();
        chk("button", 32'h01, st());
    endtask
    task automatic t_hour;
        run_cmd <= 1'b0;
        bus(1'b1, 8'h00, 32'h04);
        bus(1'b1, 8'h18, 32'h010100);
        start_pulse();
        press();
        chk("hour limit", 32'h40, st());
        wt(5, 1'b0);
        chk("hour end", 32'h0, st());
    endtask
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    initial begin
        repeat (100000) @(posedge hclk);
        n_mismatch++;
        stop_test();
    end
    initial begin
        {hresetn, hsel, hwrite, run_cmd, pump_button, trip} = 6'h0;
        {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
        load_amps = 10'h032;
        load_cos = 7'h50;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_oc();
        t_starts();
        t_therm();
        t_cont();
        t_hour();
        stop_test();
    end
endmodule
